// ### verilog/ltm_pkg.sv
// Notes on behaviour
// - Timer 0 gate bit set lets the gate pin hold off Timer 0 counting.
// - Mode 0 is a 5-bit low prescaler feeding the 8-bit high byte, 13 bits.
// - Mode 1 cascades full low and high bytes into a 16-bit counter.
// - Mode 2 counts the low byte and reloads it from the high byte on overflow.
// - Mode 3 is split mode for Timer 0 only; Timer 1 in mode 3 holds.
// - Split mode: low byte uses Timer 0 run and flag, high byte Timer 1's.
// - Mode field 00, 01, 10, 11 selects modes 0, 1, 2, 3.
// - Timer 2 offers reload counter, capture timer and baud generator.
// - Timer 2 has five registers: count pair, capture/reload pair, control.
// - Receive clock select picks Timer 2 or Timer 1 overflow for the receiver.
// - Transmit clock select picks Timer 2 or Timer 1 overflow for the transmitter.
// - Timer 2 counter select counts pin events, else internal clock.
// - Capture select set makes a trigger falling edge capture the count.
// - Timer 2 mode: stopped, baud, 16-bit auto-reload or 16-bit capture.
// - Reload on overflow, on trigger edge if enabled; baud reloads on overflow only.
// - Counter mode increments on each falling edge of the pin, sampled every clock.
// - Timer 0 and Timer 1 run bits enable and disable their timers, except that Timer 1 runs whatever its run bit while Timer 0 is in mode 3.
package ltm_pkg;
  localparam logic [7:0] LP_ADDR_TIMER01_CTRL = 8'h88;
  localparam logic [7:0] LP_ADDR_TIMER01_MODE = 8'h89;
  localparam logic [7:0] LP_ADDR_TIMER0_LOW = 8'h8A;
  localparam logic [7:0] LP_ADDR_TIMER1_LOW = 8'h8B;
  localparam logic [7:0] LP_ADDR_TIMER0_HIGH = 8'h8C;
  localparam logic [7:0] LP_ADDR_TIMER1_HIGH = 8'h8D;
  localparam logic [7:0] LP_ADDR_TIMER2_CTRL = 8'hC8;
  localparam logic [7:0] LP_ADDR_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] LP_ADDR_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] LP_ADDR_TIMER2_LOW = 8'hCC;
  localparam logic [7:0] LP_ADDR_TIMER2_HIGH = 8'hCD;
  localparam logic [7:0] LP_RESET_BYTE = 8'h00;
  // Per-timer nibble of the mode register; Timer 1 sits in the upper nibble.
  localparam int LP_MODE_T1_LSB = 4;
  localparam int LP_CFG_GATE = 3;
  localparam int LP_CFG_COUNTER = 2;
  localparam int LP_CTRL_TF1 = 7;
  localparam int LP_CTRL_TR1 = 6;
  localparam int LP_CTRL_TF0 = 5;
  localparam int LP_CTRL_TR0 = 4;
  localparam int LP_T2_OVF_FLAG = 7;
  localparam int LP_T2_EDGE_FLAG = 6;
  localparam int LP_T2_RX_CLK = 5;
  localparam int LP_T2_TX_CLK = 4;
  localparam int LP_T2_TRIG_EN = 3;
  localparam int LP_T2_RUN = 2;
  localparam int LP_T2_COUNTER = 1;
  localparam int LP_T2_CAPTURE = 0;
  localparam logic [3:0] LP_TIMER_DIV = 4'hC;
  localparam logic [3:0] LP_BAUD_DIV = 4'h2;
  typedef enum logic [1:0] {
    LTM_MODE_13 = 2'h0,
    LTM_MODE_16 = 2'h1,
    LTM_MODE_8R = 2'h2,
    LTM_MODE_SPLIT = 2'h3
  } ltm_mode_type;
endpackage : ltm_pkg

// ### verilog/ltm_tick_if.sv
`timescale 1ns/1ps
interface ltm_tick_if;
  logic tick12;
  logic tick2;
  logic fall_t0;
  logic fall_t1;
  logic fall_t2;
  logic fall_timer2_trigger_pin;
  modport src (output tick12, tick2, fall_t0, fall_t1, fall_t2, fall_timer2_trigger_pin);
  modport snk (input tick12, tick2, fall_t0, fall_t1, fall_t2, fall_timer2_trigger_pin);
endinterface : ltm_tick_if

// ### verilog/ltm_tick_gen.sv
`timescale 1ns/1ps
module ltm_tick_gen
  import ltm_pkg::*;
(
  input wire logic clk_in, // System clock.
  input wire logic rst_n_in, // Synchronised reset, active low.
  input wire logic t0_pin_in, // Timer 0 event pin.
  input wire logic t1_pin_in, // Timer 1 event pin.
  input wire logic t2_pin_in, // Timer 2 event pin.
  input wire logic timer2_trigger_pin_pin_in, // Timer 2 trigger pin.
  ltm_tick_if.src tk // Ticks and edges.
);
  logic [3:0] div12_ff;
  logic [3:0] nxt_div12;
  logic [3:0] div2_ff;
  logic [3:0] nxt_div2;
  logic [3:0] pin_ff;
  logic [3:0] nxt_pin;
  logic [3:0] pins;

  assign pins = {timer2_trigger_pin_pin_in, t2_pin_in, t1_pin_in, t0_pin_in};

  always_comb
  begin
    nxt_div12 = (div12_ff == LP_TIMER_DIV - 4'h1) ? 4'h0 : div12_ff + 4'h1;
    nxt_div2 = (div2_ff == LP_BAUD_DIV - 4'h1) ? 4'h0 : div2_ff + 4'h1;
    nxt_pin = pins;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div12_ff <= 4'h0;
      div2_ff <= 4'h0;
      pin_ff <= 4'h0;
    end
    else
    begin
      div12_ff <= nxt_div12;
      div2_ff <= nxt_div2;
      pin_ff <= nxt_pin;
    end
  end

  assign tk.tick12 = (div12_ff == LP_TIMER_DIV - 4'h1);
  assign tk.tick2 = (div2_ff == LP_BAUD_DIV - 4'h1);
  // A pin held low through reset gives no edge, since the last sample resets low.
  assign tk.fall_t0 = pin_ff[0] & ~pins[0];
  assign tk.fall_t1 = pin_ff[1] & ~pins[1];
  assign tk.fall_t2 = pin_ff[2] & ~pins[2];
  assign tk.fall_timer2_trigger_pin = pin_ff[3] & ~pins[3];
endmodule : ltm_tick_gen

// ### verilog/ltm_timers.sv
`timescale 1ns/1ps
module ltm_timers
  import ltm_pkg::*;
(
  input wire logic mclk_in, // System clock, 100 MHz.
  input wire logic nrst_in, // Asynchronous reset, active low.
  input wire logic [7:0] sfr_addr_in, // Register address.
  input wire logic sfr_wr_in, // Write strobe, active high.
  input wire logic [7:0] sfr_wdata_in, // Write data.
  output logic [7:0] sfr_rdata_out, // Read data, one cycle after address.
  input wire logic t0_pin_in, // Timer 0 event pin.
  input wire logic t1_pin_in, // Timer 1 event pin.
  input wire logic t2_pin_in, // Timer 2 event pin.
  input wire logic timer2_trigger_pin_pin_in, // Timer 2 trigger pin.
  input wire logic timer0_gate_enable_pin_in, // Timer 0 gate pin, high lets it count.
  input wire logic timer1_gate_enable_pin_in, // Timer 1 gate pin, high lets it count.
  output logic tf0_out, // Timer 0 overflow flag.
  output logic tf1_out, // Timer 1 overflow flag.
  output logic tf2_out, // Timer 2 overflow flag.
  output logic timer2_pin_edge_flag_out, // Timer 2 trigger edge flag.
  output logic rx_baud_tick_out, // Serial receiver clock pulse.
  output logic tx_baud_tick_out // Serial transmitter clock pulse.
);
  logic [1:0] rst_pipe_ff;
  logic rst_n;
  logic [7:0] ctrl_ff, mode_ff, t2ctrl_ff, tl0_ff, th0_ff, tl1_ff, th1_ff;
  logic [7:0] tl2_ff, th2_ff, rldl_ff, rldh_ff, rdata_ff;
  logic [7:0] nxt_ctrl, nxt_mode, nxt_t2ctrl, nxt_tl0, nxt_th0, nxt_tl1, nxt_th1;
  logic [7:0] nxt_tl2, nxt_th2, nxt_rldl, nxt_rldh, nxt_rdata;
  logic rx_tick_ff, tx_tick_ff, nxt_rx_tick, nxt_tx_tick;
  logic [3:0] cfg0, cfg1;
  ltm_mode_type mode0, mode1;
  logic split0, inc0, inc0h, inc1, ovf0, ovf0h, ovf1, baud, inc2, ovf2, trig2;
  logic [16:0] step0, step1;
  logic [15:0] cnt2;
  logic wr_ctrl, wr_mode, wr_t2ctrl, wr_tl0, wr_th0, wr_tl1, wr_th1;
  logic wr_tl2, wr_th2, wr_rldl, wr_rldh;

  ltm_tick_if tk();

  ltm_tick_gen u_tick_gen (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .t0_pin_in(t0_pin_in),
    .t1_pin_in(t1_pin_in),
    .t2_pin_in(t2_pin_in),
    .timer2_trigger_pin_pin_in(timer2_trigger_pin_pin_in),
    .tk(tk)
  );

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rst_pipe_ff <= 2'h0;
    else
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
  end
  assign rst_n = rst_pipe_ff[1];

  // Carry-out of the 16-bit sum lands in bit 16, so mode 1 needs no compare.
  function automatic logic [16:0] ltm_step(input ltm_mode_type m, input logic [7:0] lo,
                                            input logic [7:0] hi, input logic inc);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    if (inc)
    begin
      unique case (m)
        LTM_MODE_13:
        begin
          r[4:0] = lo[4:0] + 5'h01;
          if (lo[4:0] == 5'h1F)
            r[15:8] = hi + 8'h01;
          r[16] = (lo[4:0] == 5'h1F) && (hi == 8'hFF);
        end
        LTM_MODE_16: r = {1'b0, hi, lo} + 17'h00001;
        LTM_MODE_8R:
        begin
          r[7:0] = (lo == 8'hFF) ? hi : lo + 8'h01;
          r[16] = (lo == 8'hFF);
        end
        LTM_MODE_SPLIT: r = {1'b0, hi, lo};
      endcase
    end
    return r;
  endfunction : ltm_step

  assign wr_ctrl = sfr_wr_in && (sfr_addr_in == LP_ADDR_TIMER01_CTRL);
  assign wr_mode = sfr_wr_in && (sfr_addr_in == LP_ADDR_TIMER01_MODE);
  assign wr_t2ctrl = sfr_wr_in && (sfr_addr_in == LP_ADDR_TIMER2_CTRL);
  assign wr_tl0 = sfr_wr_in && (sfr_addr_in == LP_ADDR_TIMER0_LOW);
  assign wr_th0 = sfr_wr_in && (sfr_addr_in == LP_ADDR_TIMER0_HIGH);
  assign wr_tl1 = sfr_wr_in && (sfr_addr_in == LP_ADDR_TIMER1_LOW);
  assign wr_th1 = sfr_wr_in && (sfr_addr_in == LP_ADDR_TIMER1_HIGH);
  assign wr_tl2 = sfr_wr_in && (sfr_addr_in == LP_ADDR_TIMER2_LOW);
  assign wr_th2 = sfr_wr_in && (sfr_addr_in == LP_ADDR_TIMER2_HIGH);
  assign wr_rldl = sfr_wr_in && (sfr_addr_in == LP_ADDR_RELOAD_LOW);
  assign wr_rldh = sfr_wr_in && (sfr_addr_in == LP_ADDR_RELOAD_HIGH);

  assign cfg0 = mode_ff[3:0];
  assign cfg1 = mode_ff[LP_MODE_T1_LSB +: 4];
  assign mode0 = ltm_mode_type'(cfg0[1:0]);
  assign mode1 = ltm_mode_type'(cfg1[1:0]);
  assign split0 = (mode0 == LTM_MODE_SPLIT);
  assign inc0 = ctrl_ff[LP_CTRL_TR0] && (!cfg0[LP_CFG_GATE] || timer0_gate_enable_pin_in)
                && (cfg0[LP_CFG_COUNTER] ? tk.fall_t0 : tk.tick12);
  // In split mode the high byte borrows Timer 1's run bit and gate.
  assign inc0h = split0 && ctrl_ff[LP_CTRL_TR1] && (!cfg1[LP_CFG_GATE] || timer1_gate_enable_pin_in) && tk.tick12;
  // Timer 1's run bit is taken in split mode, so Timer 1 then runs free for baud use.
  assign inc1 = (split0 || ctrl_ff[LP_CTRL_TR1]) && (!cfg1[LP_CFG_GATE] || timer1_gate_enable_pin_in)
                && (cfg1[LP_CFG_COUNTER] ? tk.fall_t1 : tk.tick12);
  assign step0 = ltm_step(mode0, tl0_ff, th0_ff, inc0);
  assign step1 = ltm_step(mode1, tl1_ff, th1_ff, inc1);
  assign ovf0 = split0 ? (inc0 && tl0_ff == 8'hFF) : step0[16];
  assign ovf0h = inc0h && (th0_ff == 8'hFF);
  assign ovf1 = step1[16];

  assign baud = t2ctrl_ff[LP_T2_RX_CLK] || t2ctrl_ff[LP_T2_TX_CLK];
  assign inc2 = t2ctrl_ff[LP_T2_RUN] && (t2ctrl_ff[LP_T2_COUNTER] ? tk.fall_t2 :
                (baud ? tk.tick2 : tk.tick12));
  assign cnt2 = {th2_ff, tl2_ff};
  assign ovf2 = inc2 && (cnt2 == 16'hFFFF);
  assign trig2 = t2ctrl_ff[LP_T2_TRIG_EN] && tk.fall_timer2_trigger_pin;

  always_comb
  begin
    logic [15:0] c2;
    logic [15:0] r2;
    c2 = cnt2 + {15'h0000, inc2};
    r2 = {rldh_ff, rldl_ff};
    if (ovf2 && (baud || !t2ctrl_ff[LP_T2_CAPTURE]))
      c2 = r2;
    if (trig2 && !baud && !t2ctrl_ff[LP_T2_CAPTURE])
      c2 = r2;
    if (trig2 && !baud && t2ctrl_ff[LP_T2_CAPTURE])
      r2 = cnt2;
    nxt_tl0 = wr_tl0 ? sfr_wdata_in : (split0 ? tl0_ff + {7'h00, inc0} : step0[7:0]);
    nxt_th0 = wr_th0 ? sfr_wdata_in : (split0 ? th0_ff + {7'h00, inc0h} : step0[15:8]);
    nxt_tl1 = wr_tl1 ? sfr_wdata_in : step1[7:0];
    nxt_th1 = wr_th1 ? sfr_wdata_in : step1[15:8];
    nxt_tl2 = wr_tl2 ? sfr_wdata_in : c2[7:0];
    nxt_th2 = wr_th2 ? sfr_wdata_in : c2[15:8];
    nxt_rldl = wr_rldl ? sfr_wdata_in : r2[7:0];
    nxt_rldh = wr_rldh ? sfr_wdata_in : r2[15:8];
    nxt_mode = wr_mode ? sfr_wdata_in : mode_ff;
    // Hardware sets win over a software clear in the same cycle.
    nxt_ctrl = wr_ctrl ? sfr_wdata_in : ctrl_ff;
    nxt_ctrl[LP_CTRL_TF0] = nxt_ctrl[LP_CTRL_TF0] | ovf0;
    nxt_ctrl[LP_CTRL_TF1] = nxt_ctrl[LP_CTRL_TF1] | (split0 ? ovf0h : ovf1);
    nxt_t2ctrl = wr_t2ctrl ? sfr_wdata_in : t2ctrl_ff;
    nxt_t2ctrl[LP_T2_OVF_FLAG] = nxt_t2ctrl[LP_T2_OVF_FLAG] | (ovf2 && !baud);
    nxt_t2ctrl[LP_T2_EDGE_FLAG] = nxt_t2ctrl[LP_T2_EDGE_FLAG] | trig2;
    nxt_rx_tick = t2ctrl_ff[LP_T2_RX_CLK] ? ovf2 : ovf1;
    nxt_tx_tick = t2ctrl_ff[LP_T2_TX_CLK] ? ovf2 : ovf1;
    unique case (sfr_addr_in)
      LP_ADDR_TIMER01_CTRL: nxt_rdata = ctrl_ff;
      LP_ADDR_TIMER01_MODE: nxt_rdata = mode_ff;
      LP_ADDR_TIMER0_LOW: nxt_rdata = tl0_ff;
      LP_ADDR_TIMER0_HIGH: nxt_rdata = th0_ff;
      LP_ADDR_TIMER1_LOW: nxt_rdata = tl1_ff;
      LP_ADDR_TIMER1_HIGH: nxt_rdata = th1_ff;
      LP_ADDR_TIMER2_CTRL: nxt_rdata = t2ctrl_ff;
      LP_ADDR_TIMER2_LOW: nxt_rdata = tl2_ff;
      LP_ADDR_TIMER2_HIGH: nxt_rdata = th2_ff;
      LP_ADDR_RELOAD_LOW: nxt_rdata = rldl_ff;
      LP_ADDR_RELOAD_HIGH: nxt_rdata = rldh_ff;
      default: nxt_rdata = LP_RESET_BYTE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {ctrl_ff, mode_ff, t2ctrl_ff, tl0_ff, th0_ff, tl1_ff} <= {6{LP_RESET_BYTE}};
      {th1_ff, tl2_ff, th2_ff, rldl_ff, rldh_ff, rdata_ff} <= {6{LP_RESET_BYTE}};
      rx_tick_ff <= 1'b0;
      tx_tick_ff <= 1'b0;
    end
    else
    begin
      {ctrl_ff, mode_ff, t2ctrl_ff, tl0_ff, th0_ff, tl1_ff} <= {nxt_ctrl, nxt_mode, nxt_t2ctrl, nxt_tl0, nxt_th0,
                                                               nxt_tl1};
      {th1_ff, tl2_ff, th2_ff, rldl_ff, rldh_ff, rdata_ff} <= {nxt_th1, nxt_tl2, nxt_th2, nxt_rldl, nxt_rldh,
                                                               nxt_rdata};
      rx_tick_ff <= nxt_rx_tick;
      tx_tick_ff <= nxt_tx_tick;
    end
  end

  assign sfr_rdata_out = rdata_ff;
  assign tf0_out = ctrl_ff[LP_CTRL_TF0];
  assign tf1_out = ctrl_ff[LP_CTRL_TF1];
  assign tf2_out = t2ctrl_ff[LP_T2_OVF_FLAG];
  assign timer2_pin_edge_flag_out = t2ctrl_ff[LP_T2_EDGE_FLAG];
  assign rx_baud_tick_out = rx_tick_ff;
  assign tx_baud_tick_out = tx_tick_ff;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  sequence s_t0_quiet;
    !wr_tl0 && !wr_th0 && !wr_mode && !wr_ctrl;
  endsequence
  sequence s_t0_wrap16;
    mode0 == LTM_MODE_16 && inc0 && {th0_ff, tl0_ff} == 16'hFFFF ##0 s_t0_quiet;
  endsequence

  a_run_bit_stop: assert property (!ctrl_ff[LP_CTRL_TR0] && !split0 ##0 s_t0_quiet |=> $stable(tl0_ff) && $stable(th0_ff)) else $error("Timer 0 moved while stopped");
  a_gate_pin_hold: assert property (cfg0[LP_CFG_GATE] && !timer0_gate_enable_pin_in && !split0 ##0 s_t0_quiet |=> $stable(tl0_ff)) else $error("Timer 0 moved while gated off");
  a_mode0_carry: assert property (mode0 == LTM_MODE_13 && inc0 && tl0_ff[4:0] == 5'h1F ##0 s_t0_quiet |=> th0_ff == $past(th0_ff) + 8'h01 && tl0_ff[4:0] == 5'h00) else $error("Mode 0 carry wrong");
  a_mode1_wrap: assert property (s_t0_wrap16 |=> tf0_out && {th0_ff, tl0_ff} == 16'h0000) else $error("Mode 1 wrap wrong");
  a_mode2_reload: assert property (mode0 == LTM_MODE_8R && inc0 && tl0_ff == 8'hFF ##0 s_t0_quiet |=> tl0_ff == $past(th0_ff) && tf0_out) else $error("Mode 2 reload wrong");
  a_t1_split_hold: assert property (mode1 == LTM_MODE_SPLIT && !wr_tl1 && !wr_th1 |=> $stable({th1_ff, tl1_ff})) else $error("Timer 1 counted in mode 3");
  a_split_high_flag: assert property (split0 && inc0h && th0_ff == 8'hFF && !wr_th0 |=> tf1_out && th0_ff == 8'h00) else $error("Split high byte flag wrong");
  a_counter_edge: assert property (mode0 == LTM_MODE_16 && cfg0[LP_CFG_COUNTER] && ctrl_ff[LP_CTRL_TR0] && !cfg0[LP_CFG_GATE] && tk.fall_t0 && tl0_ff != 8'hFF ##0 s_t0_quiet |=> tl0_ff == $past(tl0_ff) + 8'h01) else $error("Counter edge missed");
  a_t2_capture: assert property (trig2 && !baud && t2ctrl_ff[LP_T2_CAPTURE] && !wr_rldl && !wr_rldh |=> {rldh_ff, rldl_ff} == $past(cnt2) && timer2_pin_edge_flag_out) else $error("Capture wrong");
  a_t2_baud_reload: assert property (baud && ovf2 && !wr_t2ctrl && !wr_tl2 && !wr_th2 && !tf2_out |=> {th2_ff, tl2_ff} == $past({rldh_ff, rldl_ff}) && !tf2_out) else $error("Baud reload wrong");
  a_rx_clock_src: assert property ($past(t2ctrl_ff[LP_T2_RX_CLK]) |-> rx_baud_tick_out == $past(ovf2)) else $error("Receive clock source wrong");
  a_tx_clock_src: assert property (!$past(t2ctrl_ff[LP_T2_TX_CLK]) |-> tx_baud_tick_out == $past(ovf1)) else $error("Transmit clock source wrong");
endmodule : ltm_timers

// ### verif/ltm_cpu_model.sv
`timescale 1ns/1ps
module ltm_cpu_model
  import ltm_pkg::*;
(
  input wire logic clk_in, // System clock.
  output logic [7:0] addr_out, // Register address.
  output logic wr_out, // Write strobe.
  output logic [7:0] wdata_out, // Write data.
  input wire logic [7:0] rdata_in // Registered read data.
);
  initial
  begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
  end

  // Callers enter just after a rising edge; the strobe is dropped and a full cycle passes before the next access.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    // The data lines are not left showing the written value once the strobe is gone.
    wdata_out = ~d;
    @(posedge clk_in);
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr_out = a;
    @(posedge clk_in);
    #1;
    d = rdata_in;
  endtask : rd_reg

  // The device never clears these flags, so software does it.
  task automatic clr_t2_flags();
    logic [7:0] c;
    rd_reg(LP_ADDR_TIMER2_CTRL, c);
    wr_reg(LP_ADDR_TIMER2_CTRL, c & 8'h3F);
  endtask : clr_t2_flags
endmodule : ltm_cpu_model

// ### verif/ltm_timers_test.sv
`timescale 1ns/1ps
module ltm_timers_test;
  import ltm_pkg::*;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [3:0] pins = 4'h0;
  logic [1:0] gate = 2'h0;
  logic [7:0] addr, wdata, rdata;
  logic wr;
  logic tf0, tf1, tf2, timer2_pin_edge_flag, rx_tick, tx_tick;
  wire logic [5:0] outs = {tx_tick, rx_tick, timer2_pin_edge_flag, tf2, tf1, tf0};
  int fail_count = 0;
  int n_compared = 0;

  always #5 mclk_in = ~mclk_in;

  ltm_cpu_model cpu (.clk_in(mclk_in), .addr_out(addr), .wr_out(wr), .wdata_out(wdata), .rdata_in(rdata));

  ltm_timers dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .t0_pin_in(pins[0]), .t1_pin_in(pins[1]),
    .t2_pin_in(pins[2]), .timer2_trigger_pin_pin_in(pins[3]), .timer0_gate_enable_pin_in(gate[0]), .timer1_gate_enable_pin_in(gate[1]),
    .tf0_out(tf0), .tf1_out(tf1), .tf2_out(tf2), .timer2_pin_edge_flag_out(timer2_pin_edge_flag), .rx_baud_tick_out(rx_tick),
    .tx_baud_tick_out(tx_tick));

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    cpu.rd_reg(a, d);
    chk(what, exp, d);
  endtask : chk_reg

  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : step

  // One cycle high, one cycle low, so each call gives exactly one sampled falling edge.
  task automatic pulse(input int k);
    pins[k] = 1'b1;
    step(1);
    pins[k] = 1'b0;
    step(1);
  endtask : pulse

  task automatic wait_hi(input int k, input int lim);
    int i;
    i = 0;
    while (outs[k] !== 1'b1 && i < lim)
    begin
      step(1);
      i++;
    end
    chk("output flag", 8'h01, {7'h00, outs[k]});
    if (outs[k] !== 1'b1)
      finish_test();
  endtask : wait_hi

  task automatic count_hi(input int k, input int n, output int c);
    c = 0;
    repeat (n)
    begin
      step(1);
      if (outs[k] === 1'b1)
        c++;
    end
  endtask : count_hi

  task automatic t_regs();
    chk_reg("mode reset", LP_ADDR_TIMER01_MODE, LP_RESET_BYTE);
    chk_reg("t2 ctrl reset", LP_ADDR_TIMER2_CTRL, LP_RESET_BYTE);
    cpu.wr_reg(LP_ADDR_TIMER01_MODE, 8'h5A);
    chk_reg("mode readback", LP_ADDR_TIMER01_MODE, 8'h5A);
    cpu.wr_reg(8'h90, 8'hA5);
    chk_reg("unmapped", 8'h90, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      cpu.wr_reg(8'(LP_ADDR_RELOAD_LOW + i), 8'h11 * 8'(i + 1));
      chk_reg("t2 byte", 8'(LP_ADDR_RELOAD_LOW + i), 8'h11 * 8'(i + 1));
    end
    $display("test regs done");
  endtask : t_regs

  task automatic t_mode(input int t, input logic [1:0] m, input logic [7:0] hi, lo, exp_lo, exp_hi);
    cpu.wr_reg(LP_ADDR_TIMER01_CTRL, 8'h00);
    cpu.wr_reg(LP_ADDR_TIMER01_MODE, (t == 0) ? {6'h00, m} : {2'h0, m, 4'h0});
    cpu.wr_reg(8'(LP_ADDR_TIMER0_HIGH + t), hi);
    cpu.wr_reg(8'(LP_ADDR_TIMER0_LOW + t), lo);
    cpu.wr_reg(LP_ADDR_TIMER01_CTRL, (t == 0) ? 8'h10 : 8'h40);
    wait_hi(t, 30);
    chk_reg("low after wrap", 8'(LP_ADDR_TIMER0_LOW + t), exp_lo);
    chk_reg("high after wrap", 8'(LP_ADDR_TIMER0_HIGH + t), exp_hi);
    cpu.wr_reg(LP_ADDR_TIMER01_CTRL, 8'h00);
    cpu.wr_reg(8'(LP_ADDR_TIMER0_LOW + t), 8'h12);
    step(30);
    chk_reg("stopped low", 8'(LP_ADDR_TIMER0_LOW + t), 8'h12);
    $display("test mode %0d timer %0d done", m, t);
  endtask : t_mode

  task automatic t_count();
    cpu.wr_reg(LP_ADDR_TIMER01_MODE, 8'h0D);
    cpu.wr_reg(LP_ADDR_TIMER0_LOW, 8'h00);
    cpu.wr_reg(LP_ADDR_TIMER01_CTRL, 8'h10);
    repeat (3) pulse(0);
    chk_reg("gated count", LP_ADDR_TIMER0_LOW, 8'h00);
    gate = 2'h1;
    repeat (3) pulse(0);
    chk_reg("pin count", LP_ADDR_TIMER0_LOW, 8'h03);
    $display("test count done");
  endtask : t_count

  // Only the flag of the split high byte is relied on, never an interrupt of Timer 1.
  task automatic t_split();
    cpu.wr_reg(LP_ADDR_TIMER01_CTRL, 8'h00);
    cpu.wr_reg(LP_ADDR_TIMER01_MODE, 8'h33);
    cpu.wr_reg(LP_ADDR_TIMER0_LOW, 8'h00);
    cpu.wr_reg(LP_ADDR_TIMER0_HIGH, 8'hFF);
    cpu.wr_reg(LP_ADDR_TIMER1_LOW, 8'h55);
    cpu.wr_reg(LP_ADDR_TIMER01_CTRL, 8'h40);
    wait_hi(1, 30);
    chk("split tf0", 8'h00, {7'h00, tf0});
    chk_reg("split low", LP_ADDR_TIMER0_LOW, 8'h00);
    chk_reg("t1 mode3 hold", LP_ADDR_TIMER1_LOW, 8'h55);
    $display("test split done");
  endtask : t_split

  task automatic t_t2();
    int c;
    cpu.wr_reg(LP_ADDR_TIMER01_CTRL, 8'h00);
    cpu.wr_reg(LP_ADDR_TIMER01_MODE, 8'h00);
    cpu.wr_reg(LP_ADDR_TIMER2_CTRL, 8'h09);
    cpu.wr_reg(LP_ADDR_TIMER2_LOW, 8'h34);
    cpu.wr_reg(LP_ADDR_TIMER2_HIGH, 8'h12);
    pulse(3);
    chk("edge flag", 8'h01, {7'h00, timer2_pin_edge_flag});
    chk_reg("capture low", LP_ADDR_RELOAD_LOW, 8'h34);
    chk_reg("capture high", LP_ADDR_RELOAD_HIGH, 8'h12);
    cpu.clr_t2_flags();
    chk("edge flag clear", 8'h00, {7'h00, timer2_pin_edge_flag});
    cpu.wr_reg(LP_ADDR_TIMER2_CTRL, 8'h08);
    cpu.wr_reg(LP_ADDR_RELOAD_LOW, 8'hAB);
    cpu.wr_reg(LP_ADDR_RELOAD_HIGH, 8'hCD);
    pulse(3);
    chk_reg("trig reload low", LP_ADDR_TIMER2_LOW, 8'hAB);
    chk_reg("trig reload high", LP_ADDR_TIMER2_HIGH, 8'hCD);
    cpu.wr_reg(LP_ADDR_TIMER2_CTRL, 8'h06);
    cpu.wr_reg(LP_ADDR_TIMER2_LOW, 8'hFF);
    cpu.wr_reg(LP_ADDR_TIMER2_HIGH, 8'hFF);
    pulse(2);
    chk("t2 overflow", 8'h01, {7'h00, tf2});
    chk_reg("ovf reload", LP_ADDR_TIMER2_LOW, 8'hAB);
    cpu.wr_reg(LP_ADDR_TIMER2_CTRL, 8'h00);
    cpu.wr_reg(LP_ADDR_RELOAD_LOW, 8'hFE);
    cpu.wr_reg(LP_ADDR_RELOAD_HIGH, 8'hFF);
    cpu.wr_reg(LP_ADDR_TIMER2_HIGH, 8'hFF);
    // Starting two counts below the wrap keeps the baud overflows a few cycles apart.
    cpu.wr_reg(LP_ADDR_TIMER2_LOW, 8'hFE);
    cpu.wr_reg(LP_ADDR_TIMER2_CTRL, 8'h24);
    count_hi(4, 20, c);
    chk("rx ticks seen", 8'h01, {7'h00, c > 0});
    count_hi(5, 20, c);
    chk("tx ticks from t1", 8'h00, 8'(c));
    chk("baud tf2", 8'h00, {7'h00, tf2});
    cpu.wr_reg(LP_ADDR_TIMER2_CTRL, 8'h14);
    count_hi(5, 20, c);
    chk("tx ticks seen", 8'h01, {7'h00, c > 0});
    // Timer 1 in auto-reload from 0xFF overflows on every tick and must reach the receiver.
    cpu.wr_reg(LP_ADDR_TIMER01_MODE, 8'h20);
    cpu.wr_reg(LP_ADDR_TIMER1_HIGH, 8'hFF);
    cpu.wr_reg(LP_ADDR_TIMER1_LOW, 8'hFF);
    cpu.wr_reg(LP_ADDR_TIMER01_CTRL, 8'h40);
    cpu.wr_reg(LP_ADDR_TIMER2_CTRL, 8'h10);
    count_hi(4, 30, c);
    chk("rx ticks from t1", 8'h01, {7'h00, c > 0});
    $display("test timer2 done");
  endtask : t_t2

  initial
  begin
    step(2);
    nrst_in = 1'b1;
    step(4);
    t_regs();
    t_mode(0, 2'h2, 8'hF0, 8'hFF, 8'hF0, 8'hF0);
    t_mode(0, 2'h0, 8'hFF, 8'hFF, 8'hE0, 8'h00);
    t_mode(1, 2'h1, 8'hFF, 8'hFF, 8'h00, 8'h00);
    t_count();
    t_split();
    t_t2();
    finish_test();
  end
endmodule : ltm_timers_test
